// >>> bench/spin_locked_digital_pll_bench.sv
`timescale 1ns/100ps
module spin_locked_digital_pll_bench;
  localparam int SHAPE = 20;
  logic aclk, aresetn, clk_en, sun_pulse_in, vco_in, vco_force_high, add_dir, sub_dir, in_lock;
  logic [10:0] ladder_code;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int n_fail, compares;
  int rise_n [10] = '{1024, 1030, 1030, 2048, 1100, 1100, 1100, 1100, 1024, 0};
  logic [10:0] cnt_x [10] = '{11'h000, 11'h200, 11'h203, 11'h203, 11'h400, 11'h226, 11'h226,
    11'h226, 11'h226, 11'h200};
  logic [7:0] st_x [10] = '{8'h1A, 8'h03, 8'h0C, 8'h04, 8'h1C, 8'h34, 8'h3C, 8'h74, 8'h7C, 8'h03};
  logic [10:0] corr_x [10] = '{11'h7FF, 11'h401, 11'h400, 11'h400, 11'h3FF, 11'h3FF, 11'h3FE,
    11'h3FE, 11'h3DE, 11'h3DE};

  spin_locked_digital_pll #(.SHAPE_LEN(SHAPE)) u_spin_locked_digital_pll (
    .aclk, .aresetn, .clk_en, .sun_pulse_in, .vco_in, .vco_force_high, .ladder_code, .add_dir,
    .sub_dir, .in_lock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready
  );
  sun_vco_model u_sun_vco_model (.aclk, .vco_force_high, .sun_pulse_in, .vco_in);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!aw_done || !w_done) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    // a late bready lets the answer be seen holding
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    // a late rready lets the answer be seen holding
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    rd_reg(a, rd, rs);
    chk(rd, e);
    chk({30'h0, rs}, {30'h0, er});
  endtask

  initial begin
    repeat (90000) @(posedge aclk);
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    clk_en = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk({21'h0, ladder_code}, 32'h400);
    chk({30'h0, add_dir, sub_dir}, 32'h2);
    rchk(spin_pll_pkg::OFS_CTRL, 32'h1, 2'h0);
    rchk(spin_pll_pkg::OFS_PRESET, 32'h400, 2'h0);
    rchk(spin_pll_pkg::OFS_CORR, 32'h400, 2'h0);
    rchk(spin_pll_pkg::OFS_STATUS, 32'h2, 2'h0);
    rchk(8'h14, 32'h0, spin_pll_pkg::RESP_SLVERR);
    wr(8'h14, 32'h1, rs);
    chk({30'h0, rs}, {30'h0, spin_pll_pkg::RESP_SLVERR});
    $display("reset and map test done");
    wr(spin_pll_pkg::OFS_PRESET, 32'h7FF, rs);
    wr(spin_pll_pkg::OFS_CTRL, 32'h3, rs);
    rchk(spin_pll_pkg::OFS_CTRL, 32'h1, 2'h0);
    rchk(spin_pll_pkg::OFS_CORR, 32'h7FF, 2'h0);
    $display("preset test done");
    // each pass: sun pulse samples the previous revolution, then the next one is counted
    for (int k = 0; k < 10; k++) begin
      u_sun_vco_model.sun();
      @(negedge aclk);
      chk({31'h0, vco_force_high}, 32'h1);
      repeat (SHAPE + 12) @(posedge aclk);
      chk({31'h0, vco_force_high}, 32'h0);
      rchk(spin_pll_pkg::OFS_COUNT, {21'h0, cnt_x[k]}, 2'h0);
      rchk(spin_pll_pkg::OFS_STATUS, {24'h0, st_x[k]}, 2'h0);
      chk({31'h0, in_lock}, {31'h0, st_x[k][0]});
      chk({21'h0, ladder_code}, {21'h0, corr_x[k]});
      if (k == 0) begin
        wr(spin_pll_pkg::OFS_PRESET, 32'h401, rs);
        wr(spin_pll_pkg::OFS_CTRL, 32'h3, rs);
      end
      u_sun_vco_model.rises(rise_n[k]);
    end
    $display("tracking test done");
    // loop disabled: an error revolution must leave the ladder alone
    wr(spin_pll_pkg::OFS_CTRL, 32'h0, rs);
    u_sun_vco_model.sun();
    repeat (SHAPE + 12) @(posedge aclk);
    rchk(spin_pll_pkg::OFS_CTRL, 32'h0, 2'h0);
    rchk(spin_pll_pkg::OFS_STATUS, 32'h1A, 2'h0);
    chk({21'h0, ladder_code}, 32'h3DE);
    $display("disable test done");
    conclude();
  end
endmodule // spin_locked_digital_pll_bench

// >>> bench/spin_pll_sva.sv
`timescale 1ns/100ps
module pll_checker #(
  parameter int SHAPE_LEN = 20
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // loop pins
  input wire logic sun_pulse_in,
  input wire logic vco_force_high,
  input wire logic [10:0] ladder_code,
  input wire logic add_dir,
  input wire logic sub_dir,
  input wire logic in_lock,
  // bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [15:0] high_cnt;
  logic wr_take;
  assign wr_take = s_axi_wvalid && s_axi_wready;
  always_ff @(posedge aclk) begin
    if (!aresetn || !vco_force_high) begin
      high_cnt <= 16'h0000;
    end else begin
      high_cnt <= high_cnt + 16'h0001;
    end
  end
  property p_dir_pair; add_dir != sub_dir; endproperty
  a_dir_pair: assert property (p_dir_pair) else $error("directions agree");
  property p_lock_add; in_lock && $past(in_lock) |-> add_dir; endproperty
  a_lock_add: assert property (p_lock_add) else $error("subtract while locked");
  property p_sun_force; $rose(sun_pulse_in) && !vco_force_high |-> ##[2:5] vco_force_high;
  endproperty
  a_sun_force: assert property (p_sun_force) else $error("sun pulse not shaped");
  property p_force_len;
    $fell(vco_force_high) |-> high_cnt >= SHAPE_LEN - 2 && high_cnt <= SHAPE_LEN + 2;
  endproperty
  a_force_len: assert property (p_force_len) else $error("shaped pulse length off");
  // only strobes inside the shaped window or a preset load move the ladder
  property p_ladder_cause;
    $changed(ladder_code) |-> vco_force_high || $past(vco_force_high) || $past(wr_take)
      || $past(wr_take, 2) || s_axi_bvalid || $past(s_axi_bvalid) || !$past(aresetn);
  endproperty
  a_ladder_cause: assert property (p_ladder_cause) else $error("ladder moved alone");
  property p_w_answer;
    s_axi_awvalid && s_axi_awready && wr_take |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_w_answer: assert property (p_w_answer) else $error("no write answer");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_b_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_b_busy: assert property (p_b_busy) else $error("ready during write answer");
  property p_r_answer; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid; endproperty
  a_r_answer: assert property (p_r_answer) else $error("no read answer");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  c_force: cover property ($rose(vco_force_high));
  c_slverr: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
  c_lock: cover property ($rose(in_lock));
endmodule // pll_checker

bind spin_locked_digital_pll pll_checker #(.SHAPE_LEN(SHAPE_LEN)) u_pll_checker (
  .aclk, .aresetn, .sun_pulse_in, .vco_force_high, .ladder_code, .add_dir, .sub_dir,
  .in_lock, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready
);

// >>> bench/sun_vco_model.sv
`timescale 1ns/100ps
module sun_vco_model #(
  parameter int HALF = 3
) (
  // clock
  input wire logic aclk,
  // pins
  input wire logic vco_force_high,
  output logic sun_pulse_in,
  output logic vco_in
);
  initial begin
    sun_pulse_in = 1'b0;
    vco_in = 1'b1;
  end
  task automatic sun();
    @(posedge aclk);
    sun_pulse_in <= 1'b1;
    repeat (4) @(posedge aclk);
    sun_pulse_in <= 1'b0;
  endtask
  // oscillator parks high, as the shaper forces it; exact rise counts per revolution
  task automatic rises(input int n);
    @(posedge aclk);
    while (vco_force_high !== 1'b0) @(posedge aclk);
    repeat (n) begin
      vco_in <= 1'b0;
      repeat (HALF) @(posedge aclk);
      vco_in <= 1'b1;
      repeat (HALF) @(posedge aclk);
    end
  endtask
endmodule // sun_vco_model

// >>> common/spin_pll_pkg.sv
package spin_pll_pkg;

  // clock rate and timing
  localparam int CLK_MHZ = 100;
  localparam int SHAPE_US = 60;
  localparam int SHAPE_CYCLES = SHAPE_US * CLK_MHZ;

  // loop geometry
  localparam int CORR_W = 11;
  localparam int COUNT_W = 11;
  localparam int FINE_STAGE = 0;
  localparam int COARSE_STAGE = 5;
  localparam int LOCK_STAGE = 9;
  localparam int GUARD_STAGE = 10;
  localparam int CLEAR_STAGES = 9;
  localparam int COARSE7_LSB = 4;
  localparam int COARSE6_LSB = 5;
  localparam logic [10:0] CORR_MIDSCALE = 11'h400;
  localparam logic [10:0] COUNT_TARGET = 11'h200;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CORR = 8'h0C;
  localparam logic [7:0] OFS_PRESET = 8'h10;

  // control fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_LOAD_BIT = 1;
  localparam logic CTRL_ENABLE_RST = 1'b1;

  // status fields
  localparam int ST_LOCK_BIT = 0;
  localparam int ST_ADD_BIT = 1;
  localparam int ST_SUB_BIT = 2;
  localparam int ST_CEN_BIT = 3;
  localparam int ST_CERR_BIT = 4;
  localparam int ST_Q1_BIT = 5;
  localparam int ST_Q2_BIT = 6;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // sun pulse timing sequence
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_SAMPLE = 2'b01,
    SEQ_CLEAR = 2'b11,
    SEQ_HOLD = 2'b10
  } seq_state_t;

endpackage

// >>> hdl/spin_locked_digital_pll.sv
//
// Contract
// - shaped sun pulse, 60 us, times loop
// - lock only at exact 1024 ratio
// - sample counter when sun pulse arrives
// - 11-stage counter counts halved oscillator
// - force divider high, clear nine stages (code clears all eleven, tenth and eleventh included)
// - tenth high, nine low means lock
// - tenth low means addition state
// - tenth high, lower nonzero means subtraction
// - eleventh stage guards against double ratio
// - 11-bit register drives ladder switches
// - direction selects only, strobes change register
// - fine strobe stage zero, coarse stage five
// - subtract select set only when too high
// - fine strobe needs four conditions
// - count enable toggles each sun pulse
// - coarse error on seven top stages
// - two qualifiers, cleared when six correct
// - coarse strobe needs second qualifier, enable
// - tenth stage isolated after reset
// - power-up presets correction register
`timescale 1ns/100ps
module spin_locked_digital_pll #(
  parameter int SHAPE_LEN = spin_pll_pkg::SHAPE_CYCLES,
  parameter logic [10:0] PRESET_VALUE = spin_pll_pkg::CORR_MIDSCALE
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // pins
  input wire logic sun_pulse_in,
  input wire logic vco_in,
  output logic vco_force_high,
  output logic [10:0] ladder_code,
  output logic add_dir,
  output logic sub_dir,
  output logic in_lock,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // saturating step: the control voltage must never jump end to end
  function automatic logic [10:0] sat_step(input logic [10:0] val, input logic [10:0] amt,
                                           input logic down);
    logic [11:0] wide;
    wide = 12'h000;
    if (down) begin
      wide = {1'b0, val} - {1'b0, amt};
      sat_step = wide[11] ? 11'h000 : wide[10:0];
    end else begin
      wide = {1'b0, val} + {1'b0, amt};
      sat_step = wide[11] ? 11'h7FF : wide[10:0];
    end
  endfunction

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
    merge_bytes = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge_bytes[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction

  localparam logic [10:0] FINE_AMT = 11'h001 << spin_pll_pkg::FINE_STAGE;
  localparam logic [10:0] COARSE_AMT = 11'h001 << spin_pll_pkg::COARSE_STAGE;
  localparam logic [12:0] SHAPE_LAST = 13'(SHAPE_LEN - 1);

  // pin synchronisers
  logic sun_meta_reg, sun_sync_reg, sun_prev_reg;
  logic vco_meta_reg, vco_sync_reg, vco_prev_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sun_meta_reg <= 1'b0;
      sun_sync_reg <= 1'b0;
      sun_prev_reg <= 1'b0;
      // oscillator idles high: a low reset value would count a false rise
      vco_meta_reg <= 1'b1;
      vco_sync_reg <= 1'b1;
      vco_prev_reg <= 1'b1;
    end else if (clk_en) begin
      sun_meta_reg <= sun_pulse_in;
      sun_sync_reg <= sun_meta_reg;
      sun_prev_reg <= sun_sync_reg;
      vco_meta_reg <= vco_in;
      vco_sync_reg <= vco_meta_reg;
      vco_prev_reg <= vco_sync_reg;
    end
  end

  logic sun_rise, vco_rise;
  assign sun_rise = sun_sync_reg & ~sun_prev_reg;
  assign vco_rise = vco_sync_reg & ~vco_prev_reg;

  // sun pulse shaper and timing one-shots
  spin_pll_pkg::seq_state_t seq_reg;
  logic [12:0] shape_cnt_reg;
  logic shape_reg;
  logic oneshot_a, oneshot_b, oneshot_c;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_reg <= spin_pll_pkg::SEQ_IDLE;
      shape_cnt_reg <= 13'h0000;
      shape_reg <= 1'b0;
    end else if (clk_en) begin
      case (seq_reg)
        spin_pll_pkg::SEQ_IDLE: begin
          if (sun_rise) begin
            seq_reg <= spin_pll_pkg::SEQ_SAMPLE;
            shape_reg <= 1'b1;
            shape_cnt_reg <= 13'h0000;
          end
        end
        spin_pll_pkg::SEQ_SAMPLE: begin
          seq_reg <= spin_pll_pkg::SEQ_CLEAR;
          shape_cnt_reg <= shape_cnt_reg + 13'h0001;
        end
        spin_pll_pkg::SEQ_CLEAR: begin
          seq_reg <= spin_pll_pkg::SEQ_HOLD;
          shape_cnt_reg <= shape_cnt_reg + 13'h0001;
        end
        spin_pll_pkg::SEQ_HOLD: begin
          if (shape_cnt_reg >= SHAPE_LAST) begin
            seq_reg <= spin_pll_pkg::SEQ_IDLE;
            shape_reg <= 1'b0;
          end else begin
            shape_cnt_reg <= shape_cnt_reg + 13'h0001;
          end
        end
        default: begin
          seq_reg <= spin_pll_pkg::SEQ_IDLE;
          shape_reg <= 1'b0;
        end
      endcase
    end
  end

  assign oneshot_a = (seq_reg == spin_pll_pkg::SEQ_SAMPLE);
  assign oneshot_b = (seq_reg == spin_pll_pkg::SEQ_CLEAR);
  // strobe slot at the trailing edge, after direction has settled
  assign oneshot_c = (seq_reg == spin_pll_pkg::SEQ_HOLD) && (shape_cnt_reg >= SHAPE_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vco_force_high <= 1'b0;
    end else if (clk_en) begin
      vco_force_high <= shape_reg;
    end
  end

  // half divider and frequency counter
  logic half_div_reg, half_fall;
  logic [10:0] freq_count_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_div_reg <= 1'b1;
    end else if (clk_en) begin
      if (shape_reg) begin
        half_div_reg <= 1'b1;
      end else if (vco_rise) begin
        half_div_reg <= ~half_div_reg;
      end
    end
  end

  assign half_fall = ~shape_reg & vco_rise & half_div_reg;

  logic carry9;
  assign carry9 = &freq_count_reg[8:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      freq_count_reg <= 11'h000;
    end else if (clk_en) begin
      if (oneshot_b) begin
        freq_count_reg[8:0] <= 9'h000;
        freq_count_reg[spin_pll_pkg::LOCK_STAGE] <= 1'b0;
        freq_count_reg[spin_pll_pkg::GUARD_STAGE] <= 1'b0;
      end else if (half_fall && !oneshot_a) begin
        freq_count_reg[8:0] <= freq_count_reg[8:0] + 9'h001;
        if (carry9) begin
          freq_count_reg[spin_pll_pkg::LOCK_STAGE] <= ~freq_count_reg[spin_pll_pkg::LOCK_STAGE];
          // guard set, never cleared by counting
          if (freq_count_reg[spin_pll_pkg::LOCK_STAGE]) begin
            freq_count_reg[spin_pll_pkg::GUARD_STAGE] <= 1'b1;
          end
        end
      end
    end
  end

  // classification of the sampled count
  logic count_lock, count_add, count_sub, coarse7_bad, coarse6_ok;
  logic [10:0] target;
  assign target = spin_pll_pkg::COUNT_TARGET;

  assign count_lock = (freq_count_reg == target);
  assign count_add = ~freq_count_reg[spin_pll_pkg::LOCK_STAGE] &
                     ~freq_count_reg[spin_pll_pkg::GUARD_STAGE];
  assign count_sub = ~count_lock & ~count_add;
  assign coarse7_bad = freq_count_reg[10:spin_pll_pkg::COARSE7_LSB] !=
                       target[10:spin_pll_pkg::COARSE7_LSB];
  assign coarse6_ok = freq_count_reg[10:spin_pll_pkg::COARSE6_LSB] ==
                      target[10:spin_pll_pkg::COARSE6_LSB];

  // loop control flops
  logic subtract_select_ff, count_enable_ff, coarse_error_ff;
  logic lock_qualifier_first, lock_qualifier_second, ratio_error_reg;
  logic [10:0] sampled_count_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      subtract_select_ff <= 1'b0;
      coarse_error_ff <= 1'b0;
      // no sample taken yet, so lock is not claimed
      ratio_error_reg <= 1'b1;
      sampled_count_reg <= 11'h000;
    end else if (clk_en && oneshot_a) begin
      subtract_select_ff <= count_sub;
      coarse_error_ff <= coarse7_bad;
      // any other ratio is an error
      ratio_error_reg <= ~count_lock;
      sampled_count_reg <= freq_count_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_enable_ff <= 1'b0;
    end else if (clk_en && oneshot_a) begin
      count_enable_ff <= ~count_enable_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_qualifier_first <= 1'b0;
      lock_qualifier_second <= 1'b0;
    end else if (clk_en && oneshot_a) begin
      if (coarse6_ok) begin
        lock_qualifier_first <= 1'b0;
        lock_qualifier_second <= 1'b0;
      end else if (coarse7_bad && count_enable_ff) begin
        lock_qualifier_first <= 1'b1;
        lock_qualifier_second <= lock_qualifier_first;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      add_dir <= 1'b1;
      sub_dir <= 1'b0;
      in_lock <= 1'b0;
    end else if (clk_en) begin
      add_dir <= ~subtract_select_ff;
      sub_dir <= subtract_select_ff;
      in_lock <= ~ratio_error_reg & ~lock_qualifier_first;
    end
  end

  // software control
  logic loop_enable_reg, load_pulse_reg;
  logic [10:0] preset_reg;
  logic coarse_strobe, fine_strobe;

  assign coarse_strobe = oneshot_c & lock_qualifier_second & count_enable_ff & loop_enable_reg;
  assign fine_strobe = oneshot_c & ~coarse_strobe & ratio_error_reg & count_enable_ff &
                       loop_enable_reg;

  // correction register
  logic [10:0] corr_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      corr_reg <= PRESET_VALUE;
    end else if (clk_en) begin
      if (load_pulse_reg) begin
        corr_reg <= preset_reg;
      end else if (coarse_strobe) begin
        corr_reg <= sat_step(corr_reg, COARSE_AMT, subtract_select_ff);
      end else if (fine_strobe) begin
        corr_reg <= sat_step(corr_reg, FINE_AMT, subtract_select_ff);
      end
    end
  end

  assign ladder_code = corr_reg;

  // axi4-lite write path
  logic aw_held_reg, w_held_reg;
  logic [7:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic do_write;
  assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= spin_pll_pkg::RESP_OKAY;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else if (clk_en) begin
      s_axi_awready <= ~aw_held_reg & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      s_axi_wready <= ~w_held_reg & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        waddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (waddr_reg)
          spin_pll_pkg::OFS_CTRL, spin_pll_pkg::OFS_PRESET: begin
            s_axi_bresp <= spin_pll_pkg::RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= spin_pll_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // writable registers
  logic [31:0] ctrl_merged, preset_merged;
  assign ctrl_merged = merge_bytes({30'h0, 1'b0, loop_enable_reg}, wdata_reg, wstrb_reg);
  assign preset_merged = merge_bytes({21'h0, preset_reg}, wdata_reg, wstrb_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_enable_reg <= spin_pll_pkg::CTRL_ENABLE_RST;
      load_pulse_reg <= 1'b0;
      preset_reg <= PRESET_VALUE;
    end else if (clk_en) begin
      load_pulse_reg <= 1'b0;
      if (do_write && waddr_reg == spin_pll_pkg::OFS_CTRL) begin
        loop_enable_reg <= ctrl_merged[spin_pll_pkg::CTRL_ENABLE_BIT];
        load_pulse_reg <= ctrl_merged[spin_pll_pkg::CTRL_LOAD_BIT];
      end
      if (do_write && waddr_reg == spin_pll_pkg::OFS_PRESET) begin
        preset_reg <= preset_merged[10:0];
      end
    end
  end

  // axi4-lite read path
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h00000000;
    status_word[spin_pll_pkg::ST_LOCK_BIT] = in_lock;
    status_word[spin_pll_pkg::ST_ADD_BIT] = add_dir;
    status_word[spin_pll_pkg::ST_SUB_BIT] = sub_dir;
    status_word[spin_pll_pkg::ST_CEN_BIT] = count_enable_ff;
    status_word[spin_pll_pkg::ST_CERR_BIT] = coarse_error_ff;
    status_word[spin_pll_pkg::ST_Q1_BIT] = lock_qualifier_first;
    status_word[spin_pll_pkg::ST_Q2_BIT] = lock_qualifier_second;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= spin_pll_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= spin_pll_pkg::RESP_OKAY;
        case (s_axi_araddr)
          spin_pll_pkg::OFS_CTRL: s_axi_rdata <= {31'h0, loop_enable_reg};
          spin_pll_pkg::OFS_STATUS: s_axi_rdata <= status_word;
          spin_pll_pkg::OFS_COUNT: s_axi_rdata <= {21'h0, sampled_count_reg};
          spin_pll_pkg::OFS_CORR: s_axi_rdata <= {21'h0, corr_reg};
          spin_pll_pkg::OFS_PRESET: s_axi_rdata <= {21'h0, preset_reg};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= spin_pll_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // spin_locked_digital_pll
